// *** core/mlf_pkg.sv ***
// constants and types for the multi-lane fast read engine
package mlf_pkg;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
  localparam logic [7:0] OP_DUAL_IO = 8'hBB;
  localparam logic [7:0] OP_QUAD_IO = 8'hEB;
  localparam logic [4:0] OPC_CLK_SINGLE = 5'd8;
  localparam logic [4:0] OPC_CLK_FOUR = 5'd2;
  localparam logic [4:0] ADDR_CLK_1 = 5'd24;
  localparam logic [4:0] ADDR_CLK_2 = 5'd12;
  localparam logic [4:0] ADDR_CLK_4 = 5'd6;
  localparam logic [4:0] MODE_CLK_2 = 5'd4;
  localparam logic [4:0] MODE_CLK_4 = 5'd2;
  localparam logic [4:0] DUMMY_CLK_OUT = 5'd8;
  localparam logic [4:0] DUMMY_CLK_QUAD_IO = 5'd4;
  localparam logic [1:0] CONT_SELECT_VAL = 2'b10;
  localparam logic [1:0] DUMMY_SEL_RST = 2'b00;
  localparam logic WRAP_DISABLE_RST = 1'b1;
  localparam logic [1:0] WRAP_LEN_RST = 2'b00;
  localparam logic [7:0] WRAP_MASK_BASE = 8'h07;
  localparam logic [23:0] ADDR_RST = 24'h000000;
  typedef enum logic [2:0] {ST_IDLE, ST_OPCODE, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA,
                            ST_IGNORE} mlf_state_e;
  typedef enum logic [1:0] {K_DUAL_OUT, K_QUAD_OUT, K_DUAL_IO, K_QUAD_IO} mlf_kind_e;
  typedef enum logic [1:0] {C_NONE, C_DUAL, C_QUAD} mlf_cont_e;
endpackage

// *** core/mlf_engine.sv ***
// multi-lane fast read engine with its read-data fifo
`timescale 1ns/1ns

module mlf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clear_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  output logic [$clog2(DEPTH+1)-1:0] count_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [$clog2(DEPTH+1)-1:0] cnt_r;
  wire push_w = in_valid_in && in_ready_out;
  wire pop_w = out_valid_out && out_ready_in;
  assign in_ready_out = (cnt_r != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out = mem_r[rp_r];
  assign count_out = cnt_r;
  always_ff @(posedge clock_in) begin
    if (push_w) mem_r[wp_r] <= in_data_in;
  end
  always_ff @(posedge clock_in) begin
    if (rst_in || clear_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push_w) wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      if (pop_w) rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (push_w ? 1'b1 : 1'b0) - (pop_w ? 1'b1 : 1'b0);
    end
  end
endmodule

module mlf_engine
  import mlf_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic spi_clk_in,
  input wire logic spi_sel_n_in,
  input wire logic [3:0] io_lane_in,
  output logic [3:0] io_lane_out,
  output logic [3:0] io_lane_oe_out,
  input wire logic quad_lane_enable_in,
  input wire logic write_in_progress_in,
  input wire logic four_lane_command_mode_in,
  input wire logic wrap_set_in,
  input wire logic wrap_disable_in,
  input wire logic [1:0] wrap_length_sel_in,
  input wire logic param_set_in,
  input wire logic [1:0] dummy_count_sel_in,
  input wire logic soft_reset_in,
  output logic [23:0] mem_addr_out,
  output logic mem_ready_out,
  input wire logic mem_valid_in,
  input wire logic [7:0] mem_data_in,
  output logic cont_active_out
);
  localparam int CW = $clog2(FIFO_DEPTH+1);
  // pins come from the host's domain: two flops before any use
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic sclk_d_r;
  logic sel_d_r;
  mlf_state_e state_r;
  mlf_kind_e kind_r;
  mlf_cont_e cont_r;
  logic [4:0] cnt_r;
  logic [23:0] sh_r;
  logic [23:0] addr_r;
  logic fetch_r;
  logic mem_ready_r;
  logic wrap_act_r;
  logic wrap_disable_r;
  logic [1:0] wrap_len_r;
  logic [1:0] dummy_sel_r;
  logic [7:0] out_sh_r;
  logic [1:0] out_left_r;
  logic [3:0] lane_r;
  logic [3:0] oe_r;
  logic [CW-1:0] fill_w;
  logic fifo_in_ready_w;
  logic [7:0] fifo_data_w;
  logic cont_act_r;
  wire sclk_w = sync2_r[5];
  wire sel_n_w = sync2_r[4];
  wire [3:0] io_w = sync2_r[3:0];
  wire rise_w = sclk_w && !sclk_d_r && !sel_n_w;
  wire fall_w = !sclk_w && sclk_d_r && !sel_n_w;
  wire frame_start_w = !sel_n_w && sel_d_r;
  wire last_w = (cnt_r == 5'd0);
  wire qpi_w = four_lane_command_mode_in;
  wire in_one_w = (state_r == ST_OPCODE) ? !qpi_w :
                  (kind_r == K_DUAL_OUT || kind_r == K_QUAD_OUT);
  wire in_two_w = (state_r != ST_OPCODE) && (kind_r == K_DUAL_IO);
  wire out_two_w = (kind_r == K_DUAL_OUT || kind_r == K_DUAL_IO);
  // msb first, highest lane carries the higher bit
  wire [23:0] sh_nxt = in_one_w ? {sh_r[22:0], io_w[0]} :
                       in_two_w ? {sh_r[21:0], io_w[1:0]} : {sh_r[19:0], io_w};
  wire [7:0] op_w = sh_nxt[7:0];
  wire [1:0] mode_sel_w = sh_nxt[5:4];
  wire op_dual_out_w = (op_w == OP_DUAL_OUT) && !qpi_w;
  wire op_quad_out_w = (op_w == OP_QUAD_OUT) && !qpi_w && quad_lane_enable_in;
  wire op_dual_io_w = (op_w == OP_DUAL_IO) && !qpi_w;
  wire op_quad_io_w = (op_w == OP_QUAD_IO) && quad_lane_enable_in;
  wire op_ok_w = !write_in_progress_in &&
                 (op_dual_out_w || op_quad_out_w || op_dual_io_w || op_quad_io_w);
  wire mlf_kind_e op_kind_w = op_dual_out_w ? K_DUAL_OUT : op_quad_out_w ? K_QUAD_OUT :
                              op_dual_io_w ? K_DUAL_IO : K_QUAD_IO;
  wire mlf_kind_e cont_kind_w = (cont_r == C_DUAL) ? K_DUAL_IO : K_QUAD_IO;
  wire [4:0] addr_clk_w = (kind_r == K_DUAL_IO) ? ADDR_CLK_2 :
                          (kind_r == K_QUAD_IO) ? ADDR_CLK_4 : ADDR_CLK_1;
  wire [4:0] op_addr_clk_w = (op_kind_w == K_DUAL_IO) ? ADDR_CLK_2 :
                             (op_kind_w == K_QUAD_IO) ? ADDR_CLK_4 : ADDR_CLK_1;
  wire [4:0] cont_addr_clk_w = (cont_r == C_DUAL) ? ADDR_CLK_2 : ADDR_CLK_4;
  // four-lane dummies 0/2/4/6; mode byte's 2 clocks not included
  wire [4:0] io_dummy_w = (kind_r == K_DUAL_IO) ? 5'd0 :
                          qpi_w ? {2'b00, dummy_sel_r, 1'b0} : DUMMY_CLK_QUAD_IO;
  wire [7:0] wrap_mask_w = 8'((WRAP_MASK_BASE << wrap_len_r) | WRAP_MASK_BASE);
  wire [23:0] addr_inc_w = addr_r + 24'd1;
  // wrap stays in aligned section; else linear advance
  wire [23:0] addr_next_w = wrap_act_r ?
      {addr_r[23:8], (addr_r[7:0] & ~wrap_mask_w) | (addr_inc_w[7:0] & wrap_mask_w)} :
      addr_inc_w;
  wire accept_w = mem_valid_in && mem_ready_r && fifo_in_ready_w;
  wire pop_w = fall_w && (state_r == ST_DATA) && (out_left_r == 2'd0);
  wire [7:0] byte_w = fifo_data_w;
  // reset to the idle levels (clock low, select high) so no false edge follows
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      sync1_r <= 6'h10;
      sync2_r <= 6'h10;
      sclk_d_r <= 1'b0;
      sel_d_r <= 1'b1;
    end else begin
      sync1_r <= {spi_clk_in, spi_sel_n_in, io_lane_in};
      sync2_r <= sync1_r;
      sclk_d_r <= sclk_w;
      sel_d_r <= sel_n_w;
    end
  end
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wrap_disable_r <= WRAP_DISABLE_RST;
      wrap_len_r <= WRAP_LEN_RST;
      dummy_sel_r <= DUMMY_SEL_RST;
    end else begin
      if (wrap_set_in) begin
        wrap_disable_r <= wrap_disable_in;
        wrap_len_r <= wrap_length_sel_in;
      end
      if (soft_reset_in) dummy_sel_r <= DUMMY_SEL_RST;
      else if (param_set_in) dummy_sel_r <= dummy_count_sel_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in || sel_n_w) begin
      state_r <= ST_IDLE;
      cnt_r <= 5'd0;
      sh_r <= 24'h000000;
    end else if (frame_start_w) begin
      sh_r <= 24'h000000;
      if (write_in_progress_in) begin
        state_r <= ST_IGNORE;
      // frame opens straight at the address
      end else if (cont_r != C_NONE) begin
        state_r <= ST_ADDR;
        kind_r <= cont_kind_w;
        cnt_r <= cont_addr_clk_w - 5'd1;
      end else begin
        state_r <= ST_OPCODE;
        cnt_r <= (qpi_w ? OPC_CLK_FOUR : OPC_CLK_SINGLE) - 5'd1;
      end
    end else if (rise_w) begin
      sh_r <= sh_nxt;
      cnt_r <= cnt_r - 5'd1;
      unique case (state_r)
        ST_OPCODE: if (last_w) begin
          state_r <= op_ok_w ? ST_ADDR : ST_IGNORE;
          kind_r <= op_kind_w;
          cnt_r <= op_addr_clk_w - 5'd1;
        end
        ST_ADDR: if (last_w) begin
          state_r <= (kind_r == K_DUAL_IO || kind_r == K_QUAD_IO) ? ST_MODE : ST_DUMMY;
          cnt_r <= (kind_r == K_DUAL_IO) ? MODE_CLK_2 - 5'd1 :
                   (kind_r == K_QUAD_IO) ? MODE_CLK_4 - 5'd1 : DUMMY_CLK_OUT - 5'd1;
        end
        ST_MODE: if (last_w) begin
          // quad io dummies follow the mode byte
          state_r <= (io_dummy_w == 5'd0) ? ST_DATA : ST_DUMMY;
          cnt_r <= io_dummy_w - 5'd1;
        end
        ST_DUMMY: if (last_w) state_r <= ST_DATA;
        ST_IDLE, ST_DATA, ST_IGNORE: cnt_r <= cnt_r;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cont_r <= C_NONE;
    end else if (rise_w && state_r == ST_MODE && last_w) begin
      // only bits 5:4 matter; anything else ends it
      cont_r <= (mode_sel_w != CONT_SELECT_VAL) ? C_NONE :
                (kind_r == K_DUAL_IO) ? C_DUAL : C_QUAD;
    end
  end
  always_ff @(posedge clock_in) cont_act_r <= !rst_in && (cont_r != C_NONE);
  // prefetch starts once the address is in, giving the dummies as latency
  always_ff @(posedge clock_in) begin
    if (rst_in || sel_n_w) begin
      fetch_r <= 1'b0;
      mem_ready_r <= 1'b0;
      wrap_act_r <= 1'b0;
      addr_r <= ADDR_RST;
    end else begin
      // one slot of slack covers the registered ready
      mem_ready_r <= fetch_r && (fill_w < CW'(FIFO_DEPTH - 1));
      if (rise_w && state_r == ST_ADDR && last_w) begin
        fetch_r <= 1'b1;
        addr_r <= sh_nxt;
        // wrap only for single-lane quad io
        wrap_act_r <= (kind_r == K_QUAD_IO) && !qpi_w && !wrap_disable_r;
      end else if (accept_w) begin
        addr_r <= addr_next_w;
      end
    end
  end

  // serialise bytes onto two or four lanes
  always_ff @(posedge clock_in) begin
    if (rst_in || sel_n_w) begin
      out_sh_r <= 8'h00;
      out_left_r <= 2'd0;
      lane_r <= 4'h0;
      oe_r <= 4'h0;
    end else if (fall_w && state_r == ST_DATA) begin
      oe_r <= out_two_w ? 4'h3 : 4'hF;
      if (out_left_r == 2'd0) begin
        lane_r <= out_two_w ? {2'b00, byte_w[7:6]} : byte_w[7:4];
        out_sh_r <= out_two_w ? {byte_w[5:0], 2'b00} : {byte_w[3:0], 4'h0};
        out_left_r <= out_two_w ? 2'd3 : 2'd1;
      end else begin
        lane_r <= out_two_w ? {2'b00, out_sh_r[7:6]} : out_sh_r[7:4];
        out_sh_r <= out_two_w ? {out_sh_r[5:0], 2'b00} : {out_sh_r[3:0], 4'h0};
        out_left_r <= out_left_r - 2'd1;
      end
    end
  end

  mlf_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .clear_in(sel_n_w),
    .in_valid_in(mem_valid_in && mem_ready_r),
    .in_ready_out(fifo_in_ready_w),
    .in_data_in(mem_data_in),
    .out_valid_out(),
    .out_ready_in(pop_w),
    .out_data_out(fifo_data_w),
    .count_out(fill_w)
  );

  assign io_lane_out = lane_r;
  assign io_lane_oe_out = oe_r;
  assign mem_addr_out = addr_r;
  assign mem_ready_out = mem_ready_r;
  assign cont_active_out = cont_act_r;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence seq_op_done;
    rise_w && state_r == ST_OPCODE && last_w && !sel_n_w;
  endsequence
  sequence seq_mode_done;
    rise_w && state_r == ST_MODE && last_w && !sel_n_w;
  endsequence

  chk_lanes_only_data: assert property (oe_r != 4'h0 |-> state_r == ST_DATA)
    else $error("lanes driven outside data phase");
  chk_qpi_refuse_out: assert property (
    seq_op_done ##0 (qpi_w && (op_w == OP_DUAL_OUT || op_w == OP_QUAD_OUT))
    |=> state_r == ST_IGNORE || sel_n_w)
    else $error("output-only read taken in four-lane mode");
  chk_quad_out_gate: assert property (
    seq_op_done ##0 (op_w == OP_QUAD_OUT && !quad_lane_enable_in)
    |=> state_r == ST_IGNORE || sel_n_w)
    else $error("quad output read taken without quad enable");
  chk_quad_io_gate: assert property (
    seq_op_done ##0 (op_w == OP_QUAD_IO && !quad_lane_enable_in)
    |=> state_r == ST_IGNORE || sel_n_w)
    else $error("quad io read taken without quad enable");
  chk_busy_ignore: assert property (
    seq_op_done ##0 write_in_progress_in |=> state_r == ST_IGNORE || sel_n_w)
    else $error("read taken while write in progress");
  chk_cont_entry: assert property (
    seq_mode_done ##0 (mode_sel_w == CONT_SELECT_VAL) |=> cont_r != C_NONE)
    else $error("continuation not entered");
  chk_cont_exit: assert property (
    seq_mode_done ##0 (mode_sel_w != CONT_SELECT_VAL) |=> cont_r == C_NONE)
    else $error("continuation not left");
  chk_dummy_default: assert property (
    soft_reset_in |=> dummy_sel_r == DUMMY_SEL_RST)
    else $error("dummy select not restored");
  chk_no_wrap_qpi: assert property (
    rise_w && state_r == ST_ADDR && last_w && qpi_w && !sel_n_w |=> !wrap_act_r)
    else $error("wrap active in four-lane mode");
  chk_linear_step: assert property (
    accept_w && !wrap_act_r && !(rise_w && state_r == ST_ADDR) && !sel_n_w
    |=> addr_r == $past(addr_r) + 24'd1)
    else $error("address did not advance by one");
  chk_wrap_section: assert property (
    accept_w && wrap_act_r && !sel_n_w
    |=> (addr_r & ~{16'h0000, wrap_mask_w}) == ($past(addr_r) & ~{16'h0000, wrap_mask_w}))
    else $error("wrapped address left its section");
endmodule

// *** bench/mlf_host.sv ***
// host flash controller model: drives select, serial clock and lanes
`timescale 1ns/1ns
module mlf_host #(
  parameter int HALF_NS = 160
) (
  input wire logic [3:0] dev_lane_in,
  input wire logic [3:0] dev_oe_in,
  output logic spi_clk_out,
  output logic spi_sel_n_out,
  output logic [3:0] lane_wire_out
);
  logic [3:0] drv_r = 4'h0;
  logic [3:0] drv_oe_r = 4'h0;
  logic [3:0] junk_r = 4'h5;
  initial begin
    spi_clk_out = 1'b0;
    spi_sel_n_out = 1'b1;
  end
  // released lanes float: toggle so a held value never passes for data
  always #40 junk_r = ~junk_r;
  assign lane_wire_out = (dev_oe_in & dev_lane_in) | (~dev_oe_in & drv_oe_r & drv_r)
    | (~dev_oe_in & ~drv_oe_r & junk_r);
  // clock stands low between frames; odd offset keeps phase unrelated
  task automatic select(input logic low);
    #(HALF_NS + 7);
    drv_oe_r = 4'h0;
    spi_sel_n_out = ~low;
    #(HALF_NS);
  endtask
  // lanes change while clock low, msb first
  task automatic send(input int lanes, input int nclk, input logic [31:0] val);
    logic [3:0] m;
    m = 4'((1 << lanes) - 1);
    for (int c = nclk - 1; c >= 0; c--) begin
      drv_oe_r = m;
      drv_r = 4'((val >> (c * lanes)) & 32'(m));
      #(HALF_NS);
      spi_clk_out = 1'b1;
      #(HALF_NS - 20);
      // lanes released before each fall, dummies left floating
      drv_oe_r = 4'h0;
      #20;
      spi_clk_out = 1'b0;
    end
  endtask
  task automatic recv(input int lanes, input int nbytes, output logic [7:0] got [$]);
    logic [7:0] b;
    got = {};
    for (int i = 0; i < nbytes; i++) begin
      for (int c = 0; c < 8 / lanes; c++) begin
        #(HALF_NS);
        spi_clk_out = 1'b1;
        #(HALF_NS - 10);
        b = (b << lanes) | 8'(lane_wire_out & 4'((1 << lanes) - 1));
        #10;
        spi_clk_out = 1'b0;
      end
      got.push_back(b);
    end
  endtask
endmodule

// *** bench/tb.sv ***
// self-checking bench for the multi-lane fast read engine
`timescale 1ns/1ns
module tb;
  import mlf_pkg::*;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic spi_clk, spi_sel_n;
  logic [3:0] lane_wire, lane_out, lane_oe;
  logic quad_in = 1'b1;
  logic wip_in = 1'b0;
  logic four_in = 1'b0;
  logic wrap_set_in = 1'b0;
  logic wrap_dis_in = 1'b1;
  logic [1:0] wrap_len_in = 2'h0;
  logic param_set_in = 1'b0;
  logic [1:0] dsel_in = 2'h0;
  logic soft_rst_in = 1'b0;
  logic [23:0] mem_addr;
  logic mem_ready, cont;
  logic [7:0] mem_data;
  logic any_oe;
  logic [7:0] m_cont = 8'h00;
  logic [7:0] io_ops [2] = '{OP_DUAL_IO, OP_QUAD_IO};
  int fails = 0;
  int n_compared = 0;
  int m_wdis = 1;
  int m_wlen = 0;
  int m_dsel = 0;
  int len;
  initial forever #20 clock_in = ~clock_in;
  mlf_engine #(.FIFO_DEPTH(8)) dut (.clock_in(clock_in), .rst_in(rst_in), .spi_clk_in(spi_clk),
    .spi_sel_n_in(spi_sel_n), .io_lane_in(lane_wire), .io_lane_out(lane_out),
    .io_lane_oe_out(lane_oe), .quad_lane_enable_in(quad_in), .write_in_progress_in(wip_in),
    .four_lane_command_mode_in(four_in), .wrap_set_in(wrap_set_in),
    .wrap_disable_in(wrap_dis_in), .wrap_length_sel_in(wrap_len_in),
    .param_set_in(param_set_in), .dummy_count_sel_in(dsel_in), .soft_reset_in(soft_rst_in),
    .mem_addr_out(mem_addr), .mem_ready_out(mem_ready), .mem_valid_in(1'b1),
    .mem_data_in(mem_data), .cont_active_out(cont));
  mlf_host host (.dev_lane_in(lane_out), .dev_oe_in(lane_oe), .spi_clk_out(spi_clk),
    .spi_sel_n_out(spi_sel_n), .lane_wire_out(lane_wire));
  function automatic logic [7:0] mem_byte(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction
  // memory answers 1 ns after the address, well inside one clock
  assign #1 mem_data = mem_byte(mem_addr);
  always @(posedge clock_in) if (lane_oe !== 4'h0) any_oe = 1'b1;
  function automatic logic [23:0] ra();
    return 24'($urandom);
  endfunction
  function automatic logic [23:0] next_addr(input logic [23:0] a, input logic [7:0] op);
    logic [23:0] l;
    l = 24'h000008 << m_wlen;
    // wrap only for quad io outside four-lane mode
    if (op == OP_QUAD_IO && !four_in && m_wdis == 0) return (a & ~(l - 1)) | ((a + 1) & (l - 1));
    return a + 24'h000001;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic levels(input logic q, input logic f, input logic w);
    @(posedge clock_in);
    #1;
    quad_in = q;
    four_in = f;
    wip_in = w;
  endtask
  task automatic set_wrap(input logic dis, input logic [1:0] l);
    @(posedge clock_in);
    #1;
    wrap_dis_in = dis;
    wrap_len_in = l;
    wrap_set_in = 1'b1;
    @(posedge clock_in);
    #1;
    wrap_set_in = 1'b0;
    m_wdis = dis;
    m_wlen = l;
  endtask
  task automatic set_param(input logic [1:0] sel, input logic sr);
    @(posedge clock_in);
    #1;
    dsel_in = sel;
    param_set_in = 1'b1;
    soft_rst_in = sr;
    @(posedge clock_in);
    #1;
    param_set_in = 1'b0;
    soft_rst_in = 1'b0;
    m_dsel = sr ? 0 : sel;
  endtask
  task automatic frame(input logic [7:0] op, input logic [23:0] addr, input logic [7:0] mode,
                       input int nb, input logic ok);
    logic [7:0] got [$];
    logic [23:0] a;
    int al, dl, dm;
    logic io;
    io = (op == OP_DUAL_IO) || (op == OP_QUAD_IO);
    al = (op == OP_DUAL_IO) ? 2 : (op == OP_QUAD_IO) ? 4 : 1;
    dl = (op == OP_DUAL_OUT || op == OP_DUAL_IO) ? 2 : 4;
    dm = (op == OP_QUAD_IO) ? (four_in ? 2 * m_dsel : 4) : (io ? 0 : 8);
    any_oe = 1'b0;
    host.select(1'b1);
    // opcode on lane 0, or on all four lanes in four-lane mode, skipped while continuation is armed
    if (m_cont != op) host.send(four_in ? 4 : 1, four_in ? 2 : 8, 32'(op));
    host.send(al, 24 / al, 32'(addr));
    if (io) host.send(al, 8 / al, 32'(mode));
    host.send(0, dm, 32'h0);
    host.recv(dl, nb, got);
    host.select(1'b0);
    #400;
    check("lanes driven", any_oe, ok);
    a = addr;
    for (int i = 0; i < nb && ok; i++) begin
      check("read byte", got[i], mem_byte(a));
      a = next_addr(a, op);
    end
    if (ok && io) m_cont = (mode[5:4] == CONT_SELECT_VAL) ? op : 8'h00;
    check("continuation", cont, m_cont != 8'h00);
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // whole run is near 0.4 ms of link traffic; over seven times that means a hang
  initial begin
    #3000000;
    fails++;
    summarize();
  end
  initial begin
    void'($urandom(26));
    repeat (6) @(posedge clock_in);
    #1 rst_in = 1'b0;
    repeat (4) @(posedge clock_in);
    check("oe after reset", lane_oe, 4'h0);
    frame(OP_DUAL_OUT, ra(), 8'h00, 6, 1'b1);
    levels(1'b0, 1'b0, 1'b0);
    frame(OP_QUAD_OUT, ra(), 8'h00, 2, 1'b0);
    frame(OP_QUAD_IO, ra(), 8'h00, 2, 1'b0);
    levels(1'b1, 1'b0, 1'b0);
    frame(OP_QUAD_OUT, ra(), 8'h00, 6, 1'b1);
    frame(OP_QUAD_IO, ra() | 24'h000006, 8'h00, 12, 1'b1);
    $display("done: single-lane reads");
    foreach (io_ops[k]) begin
      frame(io_ops[k], ra(), (8'($urandom) & 8'hCF) | 8'h20, 4, 1'b1);
      frame(io_ops[k], ra(), 8'hFF, 4, 1'b1);
      frame(io_ops[k], ra(), 8'h00, 4, 1'b1);
    end
    $display("done: continuation");
    for (int w = 0; w < 4; w++) begin
      set_wrap(1'b0, 2'(w));
      len = 8 << w;
      frame(OP_QUAD_IO, (ra() & ~24'(len - 1)) | 24'(len - 3), 8'h00, len + 4, 1'b1);
    end
    $display("done: wrap");
    levels(1'b1, 1'b1, 1'b0);
    frame(OP_DUAL_OUT, ra(), 8'h00, 2, 1'b0);
    frame(OP_QUAD_OUT, ra(), 8'h00, 2, 1'b0);
    frame(OP_QUAD_IO, ra() | 24'h00003E, 8'h00, 6, 1'b1);
    for (int d = 1; d < 4; d++) begin
      set_param(2'(d), 1'b0);
      frame(OP_QUAD_IO, ra(), 8'h00, 4, 1'b1);
    end
    set_param(2'h3, 1'b1);
    frame(OP_QUAD_IO, ra() | 24'h00003E, 8'hA0, 6, 1'b1);
    frame(OP_QUAD_IO, ra(), 8'hFF, 4, 1'b1);
    $display("done: four-lane mode");
    set_wrap(1'b1, 2'h0);
    levels(1'b1, 1'b0, 1'b1);
    frame(OP_DUAL_OUT, ra(), 8'h00, 2, 1'b0);
    levels(1'b1, 1'b0, 1'b0);
    fork
      frame(OP_DUAL_OUT, ra(), 8'h00, 2, 1'b0);
      begin
        // busy flag rises while the opcode is still shifting in
        repeat (40) @(posedge clock_in);
        #1 wip_in = 1'b1;
      end
    join
    levels(1'b1, 1'b0, 1'b0);
    frame(OP_DUAL_OUT, ra(), 8'h00, 3, 1'b1);
    $display("done: write in progress");
    summarize();
  end
endmodule
